// ### boot_initialize_cmd_handler_tb.sv
// self-checking bench for the initialize command handler
`timescale 1ns/100ps
`include "ibc_cfg.svh"
module boot_initialize_cmd_handler_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic rx_valid = 1'b0;
	logic [7:0] rx_data = 8'h00;
	logic rx_ready;
	logic tx_valid;
	logic [7:0] tx_data;
	logic tx_ready = 1'b0;
	logic fl_req;
	ibc_pkg::ibc_op_t fl_op;
	logic fl_ignore_protection;
	ibc_pkg::ibc_flash_rsp_t fl_rsp;
	logic [2:0] err_op = 3'h7;
	logic [2:0] last_op;
	logic req_q = 1'b0;
	logic [31:0] rd;
	logic err;
	int failures = 0;
	int checked = 0;
	int erases = 0;
	always #2.5 pclk = ~pclk;
	// refused commands must never start an erase
	always @(posedge pclk) begin
		req_q <= fl_req;
		if (fl_req === 1'b1 && req_q === 1'b0)
			erases <= erases + 1;
	end
	ibc_init_handler u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .fl_req(fl_req), .fl_op(fl_op),
		.fl_ignore_protection(fl_ignore_protection), .fl_rsp(fl_rsp));
	ibc_flash_model u_flash (.pclk(pclk), .presetn(presetn), .fl_req(fl_req), .fl_op(fl_op),
		.err_op(err_op), .fl_rsp(fl_rsp), .last_op(last_op));
	task automatic complete_run();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic hang(input int n);
		if (n >= 200) begin
			check(32'h0, 32'h1);
			complete_run();
		end
	endtask : hang
	task automatic reset_dut();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
	endtask : reset_dut
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// values read right after the edge are the ones the edge sampled
		@(posedge pclk);
		while (pready !== 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		hang(n);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// valid stays high between bytes; the packet task drops it at the end
	task automatic put(input logic [7:0] b);
		int n;
		rx_valid <= 1'b1;
		rx_data <= b;
		@(negedge pclk);
		for (n = 0; n < 200 && rx_ready !== 1'b1; n++) @(negedge pclk);
		hang(n);
		@(posedge pclk);
	endtask : put
	task automatic pkt(input logic [7:0] len, input logic [7:0] src, input logic [7:0] dst,
		input logic [7:0] bias, input logic [7:0] last);
		logic [7:0] d [4];
		logic [7:0] s;
		d = '{8'h50, src, dst, 8'h00};
		s = len;
		put(8'h5a);
		put(8'h01);
		put(8'h00);
		put(len);
		for (int i = 0; i < len; i++) begin
			put(d[i]);
			s = s + d[i];
		end
		put(8'h00 - s + bias);
		put(last);
		rx_valid <= 1'b0;
	endtask : pkt
	task automatic resp(input logic [7:0] res, input logic [7:0] sts, input logic [31:0] st2,
		input logic [31:0] adr);
		logic [7:0] e [15];
		int n;
		e = '{8'h81, 8'h00, 8'h0a, res, sts, st2[31:24], st2[23:16], st2[15:8], st2[7:0],
			adr[31:24], adr[23:16], adr[15:8], adr[7:0], 8'h00, 8'h03};
		for (int i = 1; i < 13; i++)
			e[13] = e[13] - e[i];
		for (int i = 0; i < 15; i++) begin
			@(negedge pclk);
			for (n = 0; n < 200 && tx_valid !== 1'b1; n++) @(negedge pclk);
			hang(n);
			check(tx_data, e[i]);
			// odd bytes see the sink stall one cycle longer
			if (i % 2 == 1)
				@(negedge pclk);
			@(posedge pclk);
			tx_ready <= 1'b1;
			@(posedge pclk);
			tx_ready <= 1'b0;
		end
	endtask : resp
	task automatic run(input logic [7:0] len, input logic [7:0] src, input logic [7:0] dst,
		input logic [7:0] bias, input logic [7:0] last, input logic [7:0] sts);
		pkt(len, src, dst, bias, last);
		resp(`IBC_RES_ERR, sts, `IBC_UNUSED, `IBC_UNUSED);
	endtask : run
	// a halted handler must not take even a start byte
	task automatic quiet();
		int n;
		n = 0;
		rx_valid <= 1'b1;
		rx_data <= 8'h01;
		repeat (20) begin
			@(negedge pclk);
			n = n + (rx_ready !== 1'b0);
		end
		check(n, 0);
		@(posedge pclk);
		rx_valid <= 1'b0;
	endtask : quiet
	task automatic t_checks();
		logic [11:0] a [4];
		logic [31:0] v [4];
		a = '{`IBC_A_CTRL, `IBC_A_CTRL, `IBC_A_PPV + 12'h008, `IBC_A_SPPV + 12'h010};
		v = '{32'h00000703, 32'h00000700, 32'hfffffffe, 32'h000007ff};
		apb(1'b0, `IBC_A_SPPV + 12'h010, 32'h0);
		check(rd, 32'h00000fff);
		apb(1'b1, 12'h100, 32'hffffffff);
		check(err, 1'b1);
		run(8'h03, 8'h03, 8'h02, 8'h01, 8'h04, `IBC_ST_PACKET);
		run(8'h03, 8'h04, 8'h02, 8'h01, 8'h03, `IBC_ST_CHECKSUM);
		run(8'h00, 8'h03, 8'h02, 8'h00, 8'h03, `IBC_ST_PACKET);
		run(8'h02, 8'h03, 8'h02, 8'h00, 8'h03, `IBC_ST_PACKET);
		run(8'h04, 8'h03, 8'h02, 8'h00, 8'h03, `IBC_ST_PACKET);
		apb(1'b1, `IBC_A_CTRL, 32'h00000502);
		run(8'h03, 8'h04, 8'h03, 8'h00, 8'h03, `IBC_ST_ACCEPT);
		apb(1'b1, `IBC_A_CTRL, 32'h00000702);
		run(8'h03, 8'h02, 8'h02, 8'h00, 8'h03, `IBC_ST_PARAM);
		run(8'h03, 8'h03, 8'h04, 8'h00, 8'h03, `IBC_ST_PARAM);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, a[i], v[i]);
			apb(1'b0, a[i], 32'h0);
			check(rd, v[i]);
			run(8'h03, 8'h03, 8'h02, 8'h00, 8'h03, `IBC_ST_PROTECT);
			apb(1'b1, a[i], (i < 2) ? 32'h00000702 : 32'hffffffff);
		end
		check(erases, 0);
	endtask : t_checks
	task automatic t_flash();
		for (int k = 0; k < 6; k++) begin
			err_op <= k[2:0];
			pkt(8'h03, 8'h03, 8'h02, 8'h00, 8'h03);
			resp(`IBC_RES_ERR, `IBC_ST_FLASH, 32'h0120a000, k[0] ? 32'h00004000 : `IBC_UNUSED);
			check(last_op, k[2:0]);
			apb(1'b0, `IBC_A_LCS, 32'h0);
			check(rd, 32'h00000003);
		end
		err_op <= 3'h7;
		check(erases, 6);
		apb(1'b1, `IBC_A_LCS, 32'h00000007);
		run(8'h03, 8'h07, 8'h02, 8'h00, 8'h03, `IBC_ST_HW);
		quiet();
		apb(1'b0, `IBC_A_STATUS, 32'h0);
		check(rd, 32'h00d003c6);
	endtask : t_flash
	task automatic t_ok();
		pkt(8'h03, 8'h03, 8'h02, 8'h00, 8'h03);
		resp(`IBC_RES_OK, `IBC_ST_OK, `IBC_UNUSED, `IBC_UNUSED);
		check(last_op, 3'h5);
		apb(1'b0, `IBC_A_LCS, 32'h0);
		check(rd, 32'h00000002);
		quiet();
		apb(1'b0, `IBC_A_STATUS, 32'h0);
		check(rd, 32'h00500300);
	endtask : t_ok
	initial begin
		reset_dut();
		t_checks();
		t_flash();
		reset_dut();
		t_ok();
		complete_run();
	end
endmodule : boot_initialize_cmd_handler_tb

// ### ibc_cfg.svh
// constants for the initialize command handler
`ifndef IBC_CFG_SVH
`define IBC_CFG_SVH
`define IBC_CMD_START 8'h01
`define IBC_RESP_START 8'h81
`define IBC_END_BYTE 8'h03
`define IBC_OPC_INIT 8'h50
`define IBC_RES_OK 8'h50
`define IBC_RES_ERR 8'hd0
`define IBC_CMD_LEN 16'h0003
`define IBC_RESP_LEN_H 8'h00
`define IBC_RESP_LEN_L 8'h0a
`define IBC_RESP_BYTES 4'd15
`define IBC_UNUSED 32'hffffffff
`define IBC_LC_SSD 8'h02
`define IBC_LC_NSD 8'h03
`define IBC_LC_DPL 8'h04
`define IBC_ST_OK 8'h00
`define IBC_ST_PACKET 8'hc1
`define IBC_ST_CHECKSUM 8'hc2
`define IBC_ST_ACCEPT 8'hc3
`define IBC_ST_PARAM 8'hc4
`define IBC_ST_PROTECT 8'hc5
`define IBC_ST_FLASH 8'he5
`define IBC_ST_HW 8'hc6
`define IBC_PV_BITS 140
`define IBC_PV_WORDS 5
`define IBC_PV_LAST_BITS 12
`define IBC_A_CTRL 12'h000
`define IBC_A_LCS 12'h004
`define IBC_A_STATUS 12'h008
`define IBC_A_PPV 12'h010
`define IBC_A_SPPV 12'h030
`define IBC_CTRL_INIT_DIS 0
`define IBC_CTRL_PROT_DIS 1
`define IBC_CTRL_ACC_LO 8
`define IBC_CTRL_ACC_HI 10
`define IBC_ACC_RST 3'h7
`define IBC_LCS_RST 8'h03
`endif

// ### ibc_flash_model.sv
// flash sequencer model: answers each erase step, later steps more slowly, fails on request
`timescale 1ns/100ps
module ibc_flash_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// erase requests
	input wire logic fl_req,
	input wire ibc_pkg::ibc_op_t fl_op,
	input wire logic [2:0] err_op,
	// answers
	output ibc_pkg::ibc_flash_rsp_t fl_rsp,
	output logic [2:0] last_op
);
	logic [3:0] wait_q;
	logic done_q;
	logic err_q;
	// the wait restarts after each answer so a step is never answered twice
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q <= 4'h0;
			done_q <= 1'b0;
			err_q <= 1'b0;
			last_op <= 3'h7;
		end else begin
			done_q <= 1'b0;
			wait_q <= 4'h0;
			if (fl_req && !done_q && wait_q > {1'b0, fl_op}) begin
				done_q <= 1'b1;
				err_q <= (fl_op == err_op);
				last_op <= fl_op;
			end else if (fl_req && !done_q)
				wait_q <= wait_q + 4'h1;
		end
	end
	// odd steps count as disclosed; fields outside a done pulse carry junk
	assign fl_rsp = {done_q, done_q & err_q, last_op[0],
		done_q ? 32'h0120a000 : {wait_q, 28'h5a5a5a5}, done_q ? 32'h00004000 : {28'ha5a5a5a, ~wait_q}};
endmodule : ibc_flash_model

// ### ibc_init_handler.sv
// initialize command handler: byte parser, checks, erase sequencer, response sender, apb registers
`timescale 1ns/100ps
`include "ibc_cfg.svh"
module ibc_init_handler (
	// apb clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// command byte stream
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_ready,
	// response byte stream
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	// flash sequencer
	output logic fl_req,
	output ibc_pkg::ibc_op_t fl_op,
	output logic fl_ignore_protection,
	input wire ibc_pkg::ibc_flash_rsp_t fl_rsp
);
	ibc_pkg::ibc_state_t state_q;
	logic [15:0] len_q;
	logic [15:0] cnt_q;
	logic [7:0] sum_q;
	logic [7:0] cmd_q;
	logic [7:0] src_q;
	logic [7:0] dst_q;
	logic sum_ok_q;
	logic end_ok_q;
	ibc_pkg::ibc_resp_t resp_q;
	logic [3:0] tx_idx_q;
	logic halt_after_q;
	logic tx_valid_q;
	logic [7:0] tx_data_q;
	logic rx_ready_q;
	logic fl_req_q;
	ibc_pkg::ibc_op_t fl_op_q;
	logic init_dis_q;
	logic prot_dis_q;
	logic [2:0] acc_mask_q;
	logic [7:0] lcs_q;
	logic [31:0] ppv_q [`IBC_PV_WORDS];
	logic [31:0] sppv_q [`IBC_PV_WORDS];
	logic [7:0] last_status_q;
	logic [7:0] last_result_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic rx_take;
	logic tx_take;
	logic [7:0] sum_d;
	logic pv_all_ones;
	logic lc_valid;
	logic lc_accepted;
	logic apb_wr;
	logic [7:0] resp_sum;
	logic [7:0] tx_byte;

	assign rx_take = rx_valid && rx_ready_q;
	assign tx_take = tx_valid_q && tx_ready;
	assign sum_d = sum_q + rx_data;
	assign apb_wr = psel && penable && pready_q && pwrite;

	// a word-4 bit beyond the vector width never counts as protected
	always_comb begin
		pv_all_ones = 1'b1;
		for (int i = 0; i < `IBC_PV_WORDS; i++) begin
			for (int b = 0; b < 32; b++) begin
				if ((i * 32 + b) < `IBC_PV_BITS) begin
					if (!ppv_q[i][b] || !sppv_q[i][b]) begin
						pv_all_ones = 1'b0;
					end
				end
			end
		end
	end

	assign lc_valid = (lcs_q == `IBC_LC_SSD) || (lcs_q == `IBC_LC_NSD) || (lcs_q == `IBC_LC_DPL);

	always_comb begin
		lc_accepted = 1'b0;
		if (lcs_q == `IBC_LC_SSD) begin
			lc_accepted = acc_mask_q[0];
		end else if (lcs_q == `IBC_LC_NSD) begin
			lc_accepted = acc_mask_q[1];
		end else if (lcs_q == `IBC_LC_DPL) begin
			lc_accepted = acc_mask_q[2];
		end
	end

	// response sum makes all bytes from length high to sum add to zero
	always_comb begin
		logic [7:0] s;
		s = 8'h00;
		s = s + `IBC_RESP_LEN_H + `IBC_RESP_LEN_L + resp_q.result_code + resp_q.status_code;
		for (int k = 0; k < 4; k++) begin
			s = s + resp_q.status_details[k*8 +: 8] + resp_q.address[k*8 +: 8];
		end
		resp_sum = 8'h00 - s;
	end

	// fields go out most significant byte first
	always_comb begin
		case (tx_idx_q)
			4'h0: tx_byte = `IBC_RESP_START;
			4'h1: tx_byte = `IBC_RESP_LEN_H;
			4'h2: tx_byte = `IBC_RESP_LEN_L;
			4'h3: tx_byte = resp_q.result_code;
			4'h4: tx_byte = resp_q.status_code;
			4'h5: tx_byte = resp_q.status_details[31:24];
			4'h6: tx_byte = resp_q.status_details[23:16];
			4'h7: tx_byte = resp_q.status_details[15:8];
			4'h8: tx_byte = resp_q.status_details[7:0];
			4'h9: tx_byte = resp_q.address[31:24];
			4'ha: tx_byte = resp_q.address[23:16];
			4'hb: tx_byte = resp_q.address[15:8];
			4'hc: tx_byte = resp_q.address[7:0];
			4'hd: tx_byte = resp_sum;
			default: tx_byte = `IBC_END_BYTE;
		endcase
	end

	// main sequence: parse, check in priority order, erase, answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ibc_pkg::IBC_RX_IDLE;
			len_q <= 16'h0000;
			cnt_q <= 16'h0000;
			sum_q <= 8'h00;
			cmd_q <= 8'h00;
			src_q <= 8'h00;
			dst_q <= 8'h00;
			sum_ok_q <= 1'b0;
			end_ok_q <= 1'b0;
			resp_q <= '0;
			halt_after_q <= 1'b0;
			fl_req_q <= 1'b0;
			fl_op_q <= ibc_pkg::IBC_OP_BPS;
		end else begin
			case (state_q)
				ibc_pkg::IBC_RX_IDLE: begin
					if (rx_take && rx_data == `IBC_CMD_START) begin
						state_q <= ibc_pkg::IBC_RX_LENH;
						sum_q <= 8'h00;
					end
				end
				ibc_pkg::IBC_RX_LENH: begin
					if (rx_take) begin
						len_q[15:8] <= rx_data;
						sum_q <= sum_d;
						state_q <= ibc_pkg::IBC_RX_LENL;
					end
				end
				ibc_pkg::IBC_RX_LENL: begin
					if (rx_take) begin
						len_q[7:0] <= rx_data;
						sum_q <= sum_d;
						cnt_q <= 16'h0000;
						cmd_q <= 8'h00;
						if ({len_q[15:8], rx_data} == 16'h0000) begin
							state_q <= ibc_pkg::IBC_RX_SUM;
						end else begin
							state_q <= ibc_pkg::IBC_RX_DATA;
						end
					end
				end
				ibc_pkg::IBC_RX_DATA: begin
					if (rx_take) begin
						sum_q <= sum_d;
						cnt_q <= cnt_q + 16'h0001;
						if (cnt_q == 16'h0000) begin
							cmd_q <= rx_data;
						end else if (cnt_q == 16'h0001) begin
							src_q <= rx_data;
						end else if (cnt_q == 16'h0002) begin
							dst_q <= rx_data;
						end
						if (cnt_q + 16'h0001 == len_q) begin
							state_q <= ibc_pkg::IBC_RX_SUM;
						end
					end
				end
				ibc_pkg::IBC_RX_SUM: begin
					if (rx_take) begin
						sum_ok_q <= (sum_d == 8'h00);
						state_q <= ibc_pkg::IBC_RX_END;
					end
				end
				ibc_pkg::IBC_RX_END: begin
					if (rx_take) begin
						end_ok_q <= (rx_data == `IBC_END_BYTE);
						state_q <= ibc_pkg::IBC_CHECK;
					end
				end
				ibc_pkg::IBC_CHECK: begin
					resp_q.result_code <= `IBC_RES_ERR;
					resp_q.status_details <= `IBC_UNUSED;
					resp_q.address <= `IBC_UNUSED;
					state_q <= ibc_pkg::IBC_SEND;
					// first failing condition wins; nothing touches flash before erase
					if (!end_ok_q) begin
						resp_q.status_code <= `IBC_ST_PACKET;
					end else if (!sum_ok_q) begin
						resp_q.status_code <= `IBC_ST_CHECKSUM;
					end else if (len_q == 16'h0000) begin
						resp_q.status_code <= `IBC_ST_PACKET;
					end else if (cmd_q != `IBC_OPC_INIT) begin
						state_q <= ibc_pkg::IBC_RX_IDLE; // another handler owns it
					end else if (len_q != `IBC_CMD_LEN) begin
						resp_q.status_code <= `IBC_ST_PACKET;
					end else if (!lc_valid) begin
						resp_q.status_code <= `IBC_ST_HW;
						halt_after_q <= 1'b1;
					end else if (!lc_accepted) begin
						resp_q.status_code <= `IBC_ST_ACCEPT;
					end else if (src_q != lcs_q) begin
						resp_q.status_code <= `IBC_ST_PARAM;
					end else if (dst_q != `IBC_LC_SSD) begin
						resp_q.status_code <= `IBC_ST_PARAM;
					end else if (init_dis_q || !pv_all_ones || !prot_dis_q) begin
						resp_q.status_code <= `IBC_ST_PROTECT;
					end else begin
						state_q <= ibc_pkg::IBC_ERASE;
						fl_req_q <= 1'b1;
						fl_op_q <= ibc_pkg::IBC_OP_BPS;
					end
				end
				ibc_pkg::IBC_ERASE: begin
					if (fl_rsp.done) begin
						if (fl_rsp.error) begin
							// every step fails the same way, only the address depends on disclosure
							fl_req_q <= 1'b0;
							resp_q.result_code <= `IBC_RES_ERR;
							resp_q.status_code <= `IBC_ST_FLASH;
							resp_q.status_details <= fl_rsp.status;
							resp_q.address <= fl_rsp.disclosed ? fl_rsp.addr : `IBC_UNUSED;
							state_q <= ibc_pkg::IBC_SEND;
						end else if (fl_op_q == ibc_pkg::IBC_OP_LIFECYCLE) begin
							fl_req_q <= 1'b0;
							resp_q.result_code <= `IBC_RES_OK;
							resp_q.status_code <= `IBC_ST_OK;
							resp_q.status_details <= `IBC_UNUSED;
							resp_q.address <= `IBC_UNUSED;
							halt_after_q <= 1'b1;
							state_q <= ibc_pkg::IBC_SEND;
						end else begin
							fl_op_q <= ibc_pkg::ibc_op_t'(fl_op_q + 3'b001);
						end
					end
				end
				ibc_pkg::IBC_SEND: begin
					if (tx_take && tx_idx_q == (`IBC_RESP_BYTES - 4'd1)) begin
						state_q <= halt_after_q ? ibc_pkg::IBC_HALT : ibc_pkg::IBC_RX_IDLE;
					end
				end
				ibc_pkg::IBC_HALT: begin
					state_q <= ibc_pkg::IBC_HALT;
				end
				default: begin
					state_q <= ibc_pkg::IBC_RX_IDLE;
				end
			endcase
		end
	end

	// bytes are only accepted while parsing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_ready_q <= 1'b0;
		end else begin
			rx_ready_q <= (state_q <= ibc_pkg::IBC_RX_END) && !(rx_take && state_q == ibc_pkg::IBC_RX_END);
		end
	end

	// response sender, one registered byte at a time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_idx_q <= 4'h0;
			tx_valid_q <= 1'b0;
			tx_data_q <= 8'h00;
		end else begin
			if (state_q != ibc_pkg::IBC_SEND) begin
				tx_idx_q <= 4'h0;
				tx_valid_q <= 1'b0;
			end else if (!tx_valid_q) begin
				tx_valid_q <= 1'b1;
				tx_data_q <= tx_byte;
			end else if (tx_take) begin
				tx_idx_q <= tx_idx_q + 4'h1;
				tx_valid_q <= 1'b0;
			end
		end
	end

	// lifecycle register: transition wins over a software write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lcs_q <= `IBC_LCS_RST;
		end else if (state_q == ibc_pkg::IBC_ERASE && fl_rsp.done && !fl_rsp.error &&
			fl_op_q == ibc_pkg::IBC_OP_LIFECYCLE) begin
			lcs_q <= `IBC_LC_SSD;
		end else if (apb_wr && paddr == `IBC_A_LCS) begin
			lcs_q <= pwdata[7:0];
		end
	end

	// control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_dis_q <= 1'b0;
			prot_dis_q <= 1'b1;
			acc_mask_q <= `IBC_ACC_RST;
		end else if (apb_wr && paddr == `IBC_A_CTRL) begin
			init_dis_q <= pwdata[`IBC_CTRL_INIT_DIS];
			prot_dis_q <= pwdata[`IBC_CTRL_PROT_DIS];
			acc_mask_q <= pwdata[`IBC_CTRL_ACC_HI:`IBC_CTRL_ACC_LO];
		end
	end

	// permanent protection vectors, bits above the width stay zero on read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `IBC_PV_WORDS; i++) begin
				ppv_q[i] <= `IBC_UNUSED;
				sppv_q[i] <= `IBC_UNUSED;
			end
		end else if (apb_wr) begin
			for (int i = 0; i < `IBC_PV_WORDS; i++) begin
				if (paddr == `IBC_A_PPV + 12'(i * 4)) begin
					ppv_q[i] <= pwdata;
				end
				if (paddr == `IBC_A_SPPV + 12'(i * 4)) begin
					sppv_q[i] <= pwdata;
				end
			end
		end
	end

	// last answer, for software to inspect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_status_q <= 8'h00;
			last_result_q <= 8'h00;
		end else if (tx_take && tx_idx_q == 4'h0) begin
			last_status_q <= resp_q.status_code;
			last_result_q <= resp_q.result_code;
		end
	end

	// apb: data is registered in the setup cycle, ready in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= psel && !penable;
			if (psel && !penable) begin
				pslverr_q <= 1'b0;
				prdata_q <= 32'h00000000;
				if (paddr == `IBC_A_CTRL) begin
					prdata_q[`IBC_CTRL_INIT_DIS] <= init_dis_q;
					prdata_q[`IBC_CTRL_PROT_DIS] <= prot_dis_q;
					prdata_q[`IBC_CTRL_ACC_HI:`IBC_CTRL_ACC_LO] <= acc_mask_q;
				end else if (paddr == `IBC_A_LCS) begin
					prdata_q[7:0] <= lcs_q;
				end else if (paddr == `IBC_A_STATUS) begin
					prdata_q <= {8'h00, last_result_q, 6'h00, state_q == ibc_pkg::IBC_HALT,
						state_q != ibc_pkg::IBC_RX_IDLE, last_status_q};
				end else if (paddr >= `IBC_A_PPV && paddr < `IBC_A_PPV + 12'h014 && paddr[1:0] == 2'b00) begin
					// word 0 sits where address bit 4 is set, so the index wraps like the secure one
					prdata_q <= ppv_q[3'(paddr[4:2] - 3'h4)];
					if (paddr[4:2] == 3'h0) begin
						prdata_q <= {20'h00000, ppv_q[4][`IBC_PV_LAST_BITS-1:0]};
					end
				end else if (paddr >= `IBC_A_SPPV && paddr < `IBC_A_SPPV + 12'h014 && paddr[1:0] == 2'b00) begin
					prdata_q <= sppv_q[3'(paddr[4:2] - 3'h4)];
					if (paddr[4:2] == 3'h0) begin
						prdata_q <= {20'h00000, sppv_q[4][`IBC_PV_LAST_BITS-1:0]};
					end
				end else begin
					pslverr_q <= 1'b1;
				end
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign rx_ready = rx_ready_q;
	assign tx_valid = tx_valid_q;
	assign tx_data = tx_data_q;
	assign fl_req = fl_req_q;
	assign fl_op = fl_op_q;
	assign fl_ignore_protection = fl_req_q;
endmodule : ibc_init_handler

// ### ibc_init_handler_asserts.sv
// port assertions for the initialize command handler
`timescale 1ns/100ps
`include "ibc_cfg.svh"
module ibc_init_handler_asserts (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// response stream and command stream ready
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic rx_ready,
	// flash sequencer
	input wire logic fl_req,
	input wire ibc_pkg::ibc_op_t fl_op,
	input wire logic fl_ignore_protection,
	input wire ibc_pkg::ibc_flash_rsp_t fl_rsp
);
	logic [3:0] byte_q;
	// position inside the 15 byte answer, so each field can be tied to its slot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			byte_q <= 4'h0;
		else if (tx_valid && tx_ready)
			byte_q <= (byte_q == 4'he) ? 4'h0 : byte_q + 4'h1;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ignore_prot: assert property (fl_ignore_protection == fl_req)
		else $error("erase ran without ignoring protection");
	a_resp_start: assert property (tx_valid && byte_q == 4'h0 |-> tx_data == `IBC_RESP_START)
		else $error("answer does not open with its start byte");
	a_resp_len: assert property (tx_valid && byte_q == 4'h2 |-> tx_data == `IBC_RESP_LEN_L)
		else $error("answer length byte wrong");
	a_resp_end: assert property (tx_valid && byte_q == 4'he |-> tx_data == `IBC_END_BYTE)
		else $error("answer does not close with end byte");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("answer byte lost before acceptance");
	a_erase_first: assert property ($rose(fl_req) |-> fl_op == ibc_pkg::IBC_OP_BPS)
		else $error("erase did not start with block protection");
	a_op_order: assert property (fl_rsp.done && !fl_rsp.error && fl_op != ibc_pkg::IBC_OP_LIFECYCLE
		|=> fl_req && fl_op == $past(fl_op) + 3'h1)
		else $error("erase step out of order");
	a_flash_stop: assert property (fl_rsp.done && fl_rsp.error |=> !fl_req)
		else $error("erase went on after a failed step");
	a_erase_quiet: assert property (fl_req |-> !rx_ready && !tx_valid)
		else $error("stream active during erase");
	cover property (fl_rsp.done && fl_rsp.error);
	cover property (fl_rsp.done && fl_op == ibc_pkg::IBC_OP_LIFECYCLE && !fl_rsp.error);
	cover property (tx_valid && byte_q == 4'h4 && tx_data == `IBC_ST_FLASH);
endmodule : ibc_init_handler_asserts
bind ibc_init_handler ibc_init_handler_asserts u_asserts (.pclk(pclk), .presetn(presetn),
	.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_ready(rx_ready),
	.fl_req(fl_req), .fl_op(fl_op), .fl_ignore_protection(fl_ignore_protection), .fl_rsp(fl_rsp));

// ### ibc_pkg.sv
// types for the initialize command handler
package ibc_pkg;
	typedef enum logic [2:0] {
		IBC_OP_BPS = 3'b000,
		IBC_OP_USER = 3'b001,
		IBC_OP_DATA = 3'b010,
		IBC_OP_CONFIG = 3'b011,
		IBC_OP_BOUNDARY = 3'b100,
		IBC_OP_LIFECYCLE = 3'b101
	} ibc_op_t;
	typedef enum logic [3:0] {
		IBC_RX_IDLE = 4'b0000,
		IBC_RX_LENH = 4'b0001,
		IBC_RX_LENL = 4'b0010,
		IBC_RX_DATA = 4'b0011,
		IBC_RX_SUM = 4'b0100,
		IBC_RX_END = 4'b0101,
		IBC_CHECK = 4'b0110,
		IBC_ERASE = 4'b0111,
		IBC_SEND = 4'b1000,
		IBC_HALT = 4'b1001
	} ibc_state_t;
	typedef struct packed {
		logic done;
		logic error;
		logic disclosed;
		logic [31:0] status;
		logic [31:0] addr;
	} ibc_flash_rsp_t;
	typedef struct packed {
		logic [7:0] result_code;
		logic [7:0] status_code;
		logic [31:0] status_details;
		logic [31:0] address;
	} ibc_resp_t;
endpackage : ibc_pkg
